// *** flash_protect_params.svh ***
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH
`define CLK_PERIOD_NS 20
`define T_STROBE_NS 100
`define STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HV_SETTLE_NS 1000
`define HV_SETTLE_CYC ((`T_HV_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_GO 4'h3
`define REG_STATUS 4'h4
`define REG_SHADOW 4'h5
`define CTRL_HV 0
`define CTRL_WP_HIGH 1
`define CTRL_TOP_BOOT 2
`define CTRL_RESET 3
`define CTRL_RESET_VAL 4'h6
`define GO_READ 3
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_OVERLAY 2
`define STAT_HV_READY 3
`define STAT_ALL_PROT 4
`define KIND_PLAIN 3'h0
`define KIND_PROTECT 3'h1
`define KIND_UNPROTECT 3'h2
`define KIND_ENTER 3'h3
`define KIND_EXIT 3'h4
`define KIND_LAST 3'h4
`define NUM_GROUPS 17
`define BOOT_GROUP_BASE 5'h09
`endif

// *** flash_protect_pkg.sv ***
`include "flash_protect_params.svh"
package flash_protect_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_STROBE = 4'b0100,
		ST_HOLD = 4'b1000
	} state_t;
	typedef enum logic [2:0] {
		KIND_PLAIN = `KIND_PLAIN,
		KIND_PROTECT = `KIND_PROTECT,
		KIND_UNPROTECT = `KIND_UNPROTECT,
		KIND_ENTER = `KIND_ENTER,
		KIND_EXIT = `KIND_EXIT
	} kind_t;
endpackage : flash_protect_pkg

// *** flash_protect_host.sv ***
// Behaviour
// - Permanent protect needs elevated reset voltage
// - Protect every sector before first unprotect
// - Unprotect clears all; re-protect one by one
// - Enter command overlays region on boot sectors
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "flash_protect_params.svh"
module flash_protect_host
	import flash_protect_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [19:0] flash_addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic reset_n,
	output logic high_voltage_level_en,
	output logic protect_accel_pin
);

	state_t state_q;
	kind_t kind_q;
	logic read_q;
	logic [3:0] ctrl_q;
	logic [19:0] addr_q;
	logic [15:0] data_q;
	logic [3:0] strobe_cnt_q;
	logic [7:0] hv_cnt_q;
	logic hv_ready;
	logic refused_q;
	logic overlay_q;
	logic [`NUM_GROUPS-1:0] shadow_q;
	logic all_prot;
	logic go_wr;
	logic go_ok;
	logic [2:0] go_kind;
	logic strobe_last;
	logic busy;

	// Maps A19-A12 to a protection group; bottom boot is the bitwise inverse
	function automatic logic [4:0] sector_group(input logic [7:0] sa,
		input logic top);
		logic [7:0] s;
		logic [4:0] grp;
		s = top ? sa : ~sa;
		grp = 5'h00;
		if (s[7:3] == 5'h1f)
		begin
			grp = `BOOT_GROUP_BASE + {2'b00, s[2:0]};
		end
		else if (s[7:5] == 3'b000)
		begin
			grp = (s[4:3] == 2'b00) ? 5'h00 : 5'h01;
		end
		else if (s[7:5] == 3'b111)
		begin
			grp = 5'h08;
		end
		else
		begin
			grp = {2'b00, s[7:5]} + 5'h01;
		end
		return grp;
	endfunction : sector_group

	assign busy = (state_q != ST_IDLE);
	assign all_prot = &shadow_q;
	assign hv_ready = (hv_cnt_q == 8'(`HV_SETTLE_CYC));
	assign strobe_last = (strobe_cnt_q == 4'(`STROBE_CYC - 1));
	assign go_wr = reg_wr && (reg_addr == `REG_GO);
	assign go_kind = reg_wdata[2:0];

	// Protect and unprotect cycles only go out on a settled high voltage
	always_comb
	begin
		go_ok = !busy && (go_kind <= `KIND_LAST);
		if ((go_kind == `KIND_PROTECT) || (go_kind == `KIND_UNPROTECT))
		begin
			go_ok = go_ok && ctrl_q[`CTRL_HV] && hv_ready;
		end
		if (go_kind == `KIND_UNPROTECT)
		begin
			go_ok = go_ok && all_prot;
		end
	end

	// Control is frozen during a cycle so the pins cannot move under it
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			ctrl_q <= `CTRL_RESET_VAL;
		end
		else if (clk_en && reg_wr && (reg_addr == `REG_CTRL) && !busy)
		begin
			ctrl_q <= reg_wdata[3:0];
		end
	end

	// Settle counter restarts whenever the voltage is dropped
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			hv_cnt_q <= 8'h00;
		end
		else if (clk_en)
		begin
			if (!ctrl_q[`CTRL_HV])
			begin
				hv_cnt_q <= 8'h00;
			end
			else if (!hv_ready)
			begin
				hv_cnt_q <= hv_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			addr_q <= 20'h00000;
		end
		else if (clk_en && reg_wr && (reg_addr == `REG_ADDR) && !busy)
		begin
			addr_q <= reg_wdata[19:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			data_q <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (state_q == ST_STROBE && strobe_last && read_q)
			begin
				data_q <= dq_in;
			end
			else if (reg_wr && (reg_addr == `REG_DATA) && !busy)
			begin
				data_q <= reg_wdata[15:0];
			end
		end
	end

	// Bus cycle sequencer
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			kind_q <= KIND_PLAIN;
			read_q <= 1'b0;
			strobe_cnt_q <= 4'h0;
		end
		else if (clk_en)
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (go_wr && go_ok)
					begin
						kind_q <= kind_t'(go_kind);
						read_q <= reg_wdata[`GO_READ];
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					strobe_cnt_q <= 4'h0;
					state_q <= ST_STROBE;
				end
				ST_STROBE:
				begin
					strobe_cnt_q <= strobe_cnt_q + 4'h1;
					if (strobe_last)
					begin
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Refusal is sticky; a new refusal beats a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			refused_q <= 1'b0;
		end
		else if (clk_en)
		begin
			refused_q <= (go_wr && !go_ok) || (refused_q && !(reg_wr &&
				(reg_addr == `REG_STATUS) && reg_wdata[`STAT_REFUSED]));
		end
	end

	// Host copy of the device map; parts ship unprotected
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			shadow_q <= '0;
		end
		else if (clk_en && state_q == ST_HOLD)
		begin
			if (kind_q == KIND_UNPROTECT)
			begin
				shadow_q <= '0;
			end
			else if (kind_q == KIND_PROTECT)
			begin
				shadow_q[sector_group(addr_q[19:12],
					ctrl_q[`CTRL_TOP_BOOT])] <= 1'b1;
			end
		end
	end

	// A hardware reset of the part drops the overlay as well
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			overlay_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ctrl_q[`CTRL_RESET])
			begin
				overlay_q <= 1'b0;
			end
			else if (state_q == ST_HOLD && kind_q == KIND_ENTER)
			begin
				overlay_q <= 1'b1;
			end
			else if (state_q == ST_HOLD && kind_q == KIND_EXIT)
			begin
				overlay_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			reg_rdata <= 32'h00000000;
		end
		else if (clk_en)
		begin
			reg_rdata <= 32'h00000000;
			if (reg_rd)
			begin
				unique case (reg_addr)
					`REG_CTRL: reg_rdata <= {28'h0000000, ctrl_q};
					`REG_ADDR: reg_rdata <= {12'h000, addr_q};
					`REG_DATA: reg_rdata <= {16'h0000, data_q};
					`REG_STATUS: reg_rdata <= {27'h0, all_prot,
						hv_ready, overlay_q, refused_q, busy};
					`REG_SHADOW: reg_rdata <= {15'h0, shadow_q};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign flash_addr = addr_q;
	assign dq_out = data_q;
	assign dq_oe = !read_q && (state_q == ST_SETUP || state_q == ST_STROBE);
	assign ce_n = !(state_q == ST_SETUP || state_q == ST_STROBE);
	assign we_n = !(state_q == ST_STROBE && !read_q);
	assign oe_n = !(state_q == ST_STROBE && read_q);
	assign reset_n = !ctrl_q[`CTRL_RESET];
	assign high_voltage_level_en = ctrl_q[`CTRL_HV];
	assign protect_accel_pin = ctrl_q[`CTRL_WP_HIGH];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst || !clk_en);

	// Five strobe cycles follow from the 100 ns strobe at 50 MHz
	sequence s_strobe;
		(state_q == ST_STROBE)[*5];
	endsequence
	sequence s_prot_cycle;
		(state_q == ST_STROBE) &&
			(kind_q == KIND_PROTECT || kind_q == KIND_UNPROTECT);
	endsequence

	a_strobe_width: assert property (
		$rose(state_q == ST_STROBE) |-> s_strobe ##1 (state_q == ST_HOLD))
		else $error("strobe width wrong");
	a_hv_guard: assert property (
		s_prot_cycle |-> high_voltage_level_en && hv_ready && !we_n)
		else $error("protect cycle without high voltage");
	a_unprot_order: assert property (
		(state_q == ST_SETUP && kind_q == KIND_UNPROTECT) |-> all_prot)
		else $error("unprotect with unprotected groups");
	a_unprot_clear: assert property (
		(state_q == ST_HOLD && kind_q == KIND_UNPROTECT) |=>
			(shadow_q == '0) && !busy)
		else $error("shadow not cleared by unprotect");
	a_overlay_on: assert property (
		(state_q == ST_HOLD && kind_q == KIND_ENTER && reset_n) |=>
			overlay_q)
		else $error("overlay not set after enter");
	a_overlay_off: assert property (
		(!reset_n || (state_q == ST_HOLD && kind_q == KIND_EXIT)) |=>
			!overlay_q)
		else $error("overlay kept after exit or reset");

endmodule : flash_protect_host

// *** flash_dev_model.sv ***
`timescale 1ns/1ps
module flash_dev_model
(
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] dq_out,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic reset_n,
	input wire logic protect_accel_pin,
	input wire logic top,
	output logic [15:0] dq_in
);
	logic [15:0] mem [256];
	logic [15:0] last;
	logic outer;
	logic wr_act;
	logic rd_act;
	// One word per 4 Kword block is enough to see where a write lands
	assign outer = top ? (flash_addr[19:13] == 7'h7f)
		: (flash_addr[19:13] == 7'h00);
	// Both strobes rise together, so latch as the pair releases
	assign wr_act = (ce_n === 1'b0) && (we_n === 1'b0);
	assign rd_act = (ce_n === 1'b0) && (oe_n === 1'b0);
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hffff;
		last = 16'h0000;
	end
	// Outer pair stays shut under high voltage too
	always @(negedge wr_act)
		if (reset_n === 1'b1
			&& !(outer && protect_accel_pin === 1'b0))
			mem[flash_addr[19:12]] = dq_out;
	always @(posedge rd_act)
		last = mem[flash_addr[19:12]];
	// Released bus shows the inverse so a stale value cannot pass
	assign dq_in = rd_act ? mem[flash_addr[19:12]] : ~last;
endmodule : flash_dev_model

// *** flash_sector_protection_tb.sv ***
`timescale 1ns/1ps
`include "flash_protect_params.svh"
`define chk(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module flash_sector_protection_tb
	import flash_protect_pkg::*;
;
	logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, st, v;
	logic [19:0] flash_addr;
	logic [15:0] dq_in, dq_out;
	logic dq_oe, ce_n, we_n, oe_n, reset_n;
	logic high_voltage_level_en, protect_accel_pin;
	logic clk_en = 1'b1;
	int errors = 0, total_checks = 0, cyc = 0;
	int wlow = 0, olow = 0, clow = 0, dhigh = 0, w0, o0, c0, d0;
	logic [7:0] grp [9] = '{8'h00, 8'h08, 8'h20, 8'h40, 8'h60, 8'h80,
		8'ha0, 8'hc0, 8'he0};
	flash_protect_host u_flash_protect_host(.mclk, .nrst, .clk_en,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr,
		.dq_in, .dq_out, .dq_oe, .ce_n, .we_n, .oe_n, .reset_n,
		.high_voltage_level_en, .protect_accel_pin);
	flash_dev_model u_flash_dev_model(.flash_addr, .dq_out, .ce_n, .we_n,
		.oe_n, .reset_n, .protect_accel_pin, .top(1'b1), .dq_in);
	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		wlow += (we_n === 1'b0);
		olow += (oe_n === 1'b0);
		clow += (ce_n === 1'b0);
		dhigh += (dq_oe === 1'b1);
	end
	task snap();
		w0 = wlow;
		o0 = olow;
		c0 = clow;
		d0 = dhigh;
	endtask : snap
	task report_and_stop();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// Polling is bounded so a stuck busy flag ends in a mismatch
	task go(input logic [3:0] k);
		wr(`REG_GO, {28'h0, k});
		repeat (20)
		begin
			rd(`REG_STATUS, st);
			if (st[`STAT_BUSY] === 1'b0) break;
		end
		`chk(st[`STAT_BUSY], 1'b0)
	endtask : go
	task t_reset();
		rd(`REG_CTRL, v); `chk(v, 32'h6)
		rd(`REG_SHADOW, v); `chk(v, 32'h0)
		rd(4'hf, v); `chk(v, 32'h0)
		`chk(high_voltage_level_en, 1'b0)
		$display("reset test done");
	endtask : t_reset
	// A frozen block must ignore a register write entirely
	task t_freeze();
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(`REG_CTRL, 32'h4);
		`chk(protect_accel_pin, 1'b1)
		@(posedge mclk);
		clk_en <= 1'b1;
		rd(`REG_CTRL, v); `chk(v, 32'h6)
		$display("freeze test done");
	endtask : t_freeze
	task t_cycle();
		wr(`REG_ADDR, 32'h12345);
		rd(`REG_ADDR, v); `chk(v, 32'h12345)
		wr(`REG_DATA, 32'hbeef);
		snap();
		go({1'b0, KIND_PLAIN});
		`chk(wlow - w0, `STROBE_CYC)
		`chk(clow - c0, `STROBE_CYC + 1)
		`chk(dhigh - d0, `STROBE_CYC + 1)
		`chk(olow - o0, 0)
		wr(`REG_DATA, 32'h0);
		snap();
		go({1'b1, KIND_PLAIN});
		`chk(olow - o0, `STROBE_CYC)
		`chk(clow - c0, `STROBE_CYC + 1)
		`chk(dhigh - d0, 0)
		`chk(wlow - w0, 0)
		rd(`REG_DATA, v); `chk(v, 32'hbeef)
		wr(`REG_CTRL, 32'h4);
		`chk(protect_accel_pin, 1'b0)
		wr(`REG_ADDR, 32'hff000);
		go({1'b0, KIND_PLAIN});
		go({1'b1, KIND_PLAIN});
		rd(`REG_DATA, v); `chk(v, 32'hffff)
		wr(`REG_CTRL, 32'h6);
		wr(`REG_DATA, 32'h1234);
		go({1'b0, KIND_PLAIN});
		go({1'b1, KIND_PLAIN});
		rd(`REG_DATA, v); `chk(v, 32'h1234)
		$display("cycle test done");
	endtask : t_cycle
	task t_protect();
		go({1'b0, KIND_PROTECT});
		`chk(st[`STAT_REFUSED], 1'b1)
		wr(`REG_STATUS, 32'h2);
		wr(`REG_CTRL, 32'h7);
		`chk(high_voltage_level_en, 1'b1)
		repeat (`HV_SETTLE_CYC + 4) @(posedge mclk);
		wr(`REG_ADDR, 32'hf8000);
		go({1'b0, KIND_PROTECT});
		rd(`REG_SHADOW, v); `chk(v, 32'h200)
		go({1'b0, KIND_UNPROTECT});
		`chk(st[`STAT_REFUSED], 1'b1)
		wr(`REG_STATUS, 32'h2);
		for (int i = 0; i < 17; i++)
		begin
			wr(`REG_ADDR, {12'h0, (i < 9) ? grp[i] : 8'hef + 8'(i), 12'h0});
			go({1'b0, KIND_PROTECT});
		end
		`chk(st[`STAT_ALL_PROT], 1'b1)
		go({1'b0, KIND_UNPROTECT});
		`chk(st[`STAT_REFUSED], 1'b0)
		rd(`REG_SHADOW, v); `chk(v, 32'h0)
		wr(`REG_ADDR, 32'h0);
		go({1'b0, KIND_PROTECT});
		rd(`REG_SHADOW, v); `chk(v, 32'h1)
		wr(`REG_CTRL, 32'h3);
		go({1'b0, KIND_PROTECT});
		rd(`REG_SHADOW, v); `chk(v, 32'h10001)
		wr(`REG_CTRL, 32'h6);
		$display("protect test done");
	endtask : t_protect
	task t_overlay();
		go(4'h5);
		`chk(st[`STAT_REFUSED], 1'b1)
		wr(`REG_STATUS, 32'h2);
		rd(`REG_STATUS, v); `chk(v[`STAT_REFUSED], 1'b0)
		go({1'b0, KIND_ENTER});
		`chk(st[`STAT_OVERLAY], 1'b1)
		go({1'b0, KIND_EXIT});
		`chk(st[`STAT_OVERLAY], 1'b0)
		go({1'b0, KIND_ENTER});
		wr(`REG_CTRL, 32'he);
		`chk(reset_n, 1'b0)
		rd(`REG_STATUS, v); `chk(v[`STAT_OVERLAY], 1'b0)
		wr(`REG_CTRL, 32'h6);
		$display("overlay test done");
	endtask : t_overlay
	initial
	begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		fork
			begin
				t_reset();
				t_freeze();
				t_cycle();
				t_protect();
				t_overlay();
			end
			begin
				while (cyc < 20000) @(posedge mclk);
				errors++;
			end
		join_any
		report_and_stop();
	end
endmodule : flash_sector_protection_tb
